// ==== bdm_pkg.sv ====
// Package: constants and carriers for the banked data memory block
package bdm_pkg;
    localparam int          DATA_W        = 8;
    localparam int          FIELD_W       = 5;
    localparam int          ADDR_W        = 8;
    localparam int          GLOBAL_W      = 4;
    localparam int          BANK_COUNT    = 16;
    localparam int          BANK_REGS     = 16;
    localparam int          MEM_WORDS     = BANK_COUNT * BANK_REGS;
    localparam int          GLOBAL_REGS   = 16;
    localparam int          SPECIAL_COUNT = 9;
    localparam logic [4:0]  FIELD_INDIRECT     = 5'h00;
    localparam int          FIELD_SEMI_BIT     = 4;
    localparam logic [3:0]  ADDR_INDIRECT_PORT = 4'h0;
    localparam logic [3:0]  ADDR_BANK_POINTER  = 4'h4;
    localparam logic [7:0]  BANK_POINTER_RESET = 8'h00;
    localparam logic [7:0]  BANK_SELECT_MASK   = 8'h70;
    localparam int          BLOCK_BIT          = 7;

    // Access modes, one-hot
    typedef enum logic [2:0] {
        BDM_INDIRECT = 3'b001,
        BDM_DIRECT   = 3'b010,
        BDM_SEMI     = 3'b100
    } bdm_mode_t;

    // Operation kinds from the execution logic
    typedef enum logic [3:0] {
        BDM_OP_NONE  = 4'b0001,
        BDM_OP_WRITE = 4'b0010,
        BDM_OP_BANK  = 4'b0100,
        BDM_OP_INC   = 4'b1000
    } bdm_op_t;

    // One request from the execution logic
    typedef struct packed {
        bdm_op_t     op;
        logic [4:0]  register_field;
        logic [7:0]  wdata;
    } bdm_req_t;

    // Resolved target of a request
    typedef struct packed {
        logic        is_global;
        logic        valid;
        logic [7:0]  addr;
    } bdm_target_t;
endpackage

// ==== bdm_ram.sv ====
// Banked general-purpose storage, registered read data
`timescale 1ns/1ns
`default_nettype none
module bdm_ram (
    input  wire logic                     clk,
    input  wire logic                     we,
    input  wire logic [bdm_pkg::ADDR_W-1:0] waddr,
    input  wire logic [bdm_pkg::DATA_W-1:0] wdata,
    input  wire logic [bdm_pkg::ADDR_W-1:0] raddr,
    output var  logic [bdm_pkg::DATA_W-1:0] rdata
);
    import bdm_pkg::*;

    logic [DATA_W-1:0] mem [MEM_WORDS];

    // Write port and registered read port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ==== bdm_core.sv ====
// Banked data memory with indirect, direct and semi-direct addressing
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Eight-bit storage: sixteen banks of sixteen, plus a global bank of sixteen.
// - Each access carries a five-bit register field choosing mode and target.
// - Field zero is indirect, 01h-0Fh direct, 10h-1Fh semi-direct.
// - Indirect mode uses the whole bank pointer at global 04h as address.
// - Indirect pointer 01h-0Fh reaches global bank, higher reaches banks 1-F.
// - Direct mode reaches only the global bank, pointer ignored.
// - Semi-direct address is pointer high nibble with field low nibble.
// - Global zero is the indirect port; nine globals special, banks general.
// - Bank select replaces only pointer bits 4 to 6.
// - Pointer bit 7 picks lower block 00-7F or upper block 80-FF.
// - Bank pointer is an ordinary global register, writable as a byte.
// - Incrementing the pointer past FFh wraps to 00h.
module bdm_core (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire bdm_pkg::bdm_req_t         req,
    input  wire logic [7:0]                special_rdata,
    output var  logic [7:0]                rdata,
    output var  bdm_pkg::bdm_target_t      target,
    output var  bdm_pkg::bdm_mode_t        mode,
    output var  logic                      special_we,
    output var  logic [3:0]                special_addr,
    output var  logic [7:0]                special_wdata,
    output var  logic [7:0]                bank_pointer_q
);
    import bdm_pkg::*;

    // Mode decode, shared by read and write paths
    function automatic bdm_mode_t decode_mode(input logic [4:0] f);
        if (f == FIELD_INDIRECT) begin
            decode_mode = BDM_INDIRECT;
        end else if (f[FIELD_SEMI_BIT]) begin
            decode_mode = BDM_SEMI;
        end else begin
            decode_mode = BDM_DIRECT;
        end
    endfunction

    // Target resolution from field and pointer
    function automatic bdm_target_t resolve(input logic [4:0] f, input logic [7:0] p);
        bdm_target_t t;
        t = '0;
        case (decode_mode(f))
            BDM_INDIRECT: begin
                t.addr      = p;
                t.is_global = (p[7:4] == 4'h0);
                t.valid     = (p != 8'h00);
            end
            BDM_DIRECT: begin
                t.addr      = {4'h0, f[3:0]};
                t.is_global = 1'b1;
                t.valid     = 1'b1;
            end
            BDM_SEMI: begin
                t.addr      = {p[7:4], f[3:0]};
                t.is_global = 1'b0;
                t.valid     = 1'b1;
            end
            default: begin
                t = '0;
            end
        endcase
        resolve = t;
    endfunction

    logic [7:0]  bank_pointer;
    logic [7:0]  next_bank_pointer;
    logic [7:0]  gp_reg [GLOBAL_REGS];
    logic [7:0]  next_gp_reg [GLOBAL_REGS];
    logic [7:0]  next_rdata;
    logic        ram_we;
    logic [7:0]  ram_rdata;
    logic [7:0]  cur_value;
    logic [7:0]  new_value;
    logic        writes;
    logic        bank_sel;
    logic        glob_wr;
    logic        ptr_wr;
    logic        rd_global;
    logic        rd_special;
    logic [3:0]  rd_gaddr;
    logic [7:0]  rd_gdata;
    bdm_target_t tgt;

    // Seven specials (globals 1-3 and 5-8) live outside this block; the rest are local
    function automatic logic is_special(input logic [3:0] a);
        is_special = (a <= 4'(SPECIAL_COUNT - 1)) && (a != ADDR_BANK_POINTER)
                     && (a != ADDR_INDIRECT_PORT);
    endfunction

    // Plain storage locations of the global bank
    function automatic logic is_local(input logic [3:0] a);
        is_local = !is_special(a) && (a != ADDR_BANK_POINTER)
                   && (a != ADDR_INDIRECT_PORT);
    endfunction

    // Combinational decode of the current request
    always_comb begin
        tgt        = resolve(req.register_field, bank_pointer);
        mode       = decode_mode(req.register_field);
        target     = tgt;
        writes     = (req.op == BDM_OP_WRITE) || (req.op == BDM_OP_INC);
        bank_sel   = (req.op == BDM_OP_BANK);
        rd_global  = tgt.is_global;
        rd_gaddr   = tgt.addr[3:0];
        rd_special = is_special(tgt.addr[3:0]);
    end

    // Global-bank read value for the current target
    always_comb begin
        if (rd_gaddr == ADDR_BANK_POINTER) begin
            rd_gdata = bank_pointer;
        end else if (rd_special) begin
            rd_gdata = special_rdata;
        end else if (rd_gaddr == ADDR_INDIRECT_PORT) begin
            rd_gdata = 8'h00;
        end else begin
            rd_gdata = gp_reg[rd_gaddr];
        end
    end

    // Old value of the target and the value written back
    always_comb begin
        cur_value = rd_global ? rd_gdata : ram_rdata;
        if (req.op == BDM_OP_INC) begin
            new_value = 8'(cur_value + 8'h01);
        end else begin
            new_value = req.wdata;
        end
    end

    // Write strobes for the pointer, the specials and the bank RAM
    always_comb begin
        glob_wr       = writes && tgt.valid && rd_global;
        ptr_wr        = glob_wr && (rd_gaddr == ADDR_BANK_POINTER);
        special_we    = glob_wr && rd_special;
        special_addr  = rd_gaddr;
        special_wdata = new_value;
        ram_we        = writes && tgt.valid && !rd_global;
    end

    // Bank select merges bits 6:4; a byte write or increment replaces all
    always_comb begin
        if (bank_sel) begin
            next_bank_pointer = (bank_pointer & ~BANK_SELECT_MASK)
                                | (req.wdata & BANK_SELECT_MASK);
        end else if (ptr_wr) begin
            next_bank_pointer = new_value;
        end else begin
            next_bank_pointer = bank_pointer;
        end
    end

    // Pointer register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bank_pointer <= BANK_POINTER_RESET;
        end else begin
            bank_pointer <= next_bank_pointer;
        end
    end

    // Local general-purpose globals, one register per location
    for (genvar g = 0; g < GLOBAL_REGS; g++) begin : g_glob
        // Load on a write aimed at this location
        always_comb begin
            if (glob_wr && is_local(4'(g)) && (rd_gaddr == 4'(g))) begin
                next_gp_reg[g] = new_value;
            end else begin
                next_gp_reg[g] = gp_reg[g];
            end
        end

        // Storage flop
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                gp_reg[g] <= 8'h00;
            end else begin
                gp_reg[g] <= next_gp_reg[g];
            end
        end
    end

    // Read data of this cycle's target; a refused target reads zero
    always_comb begin
        if (tgt.valid) begin
            next_rdata = cur_value;
        end else begin
            next_rdata = 8'h00;
        end
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Pointer as seen by the execution logic
    assign bank_pointer_q = bank_pointer;

    // Bank storage, read address follows the current target
    bdm_ram u_ram (
        .clk   (clk),
        .we    (ram_we),
        .waddr (tgt.addr),
        .wdata (new_value),
        .raddr (tgt.addr),
        .rdata (ram_rdata)
    );
endmodule
`default_nettype wire

// ==== bdm_monitor.sv ====
// Checker for address decode and pointer updates
`timescale 1ns/1ns
`default_nettype none
module bdm_monitor (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire bdm_pkg::bdm_req_t    req,
    input wire bdm_pkg::bdm_target_t target,
    input wire bdm_pkg::bdm_mode_t   mode,
    input wire logic                 special_we,
    input wire logic [3:0]           special_addr,
    input wire logic [7:0]           bank_pointer_q
);
    import bdm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Field and write data as plain vectors
    wire logic [4:0] fld = req.register_field;
    wire logic [7:0] wd  = req.wdata;
    sequence s_ptr_full;
        req.op == BDM_OP_INC && fld == 5'h04 && bank_pointer_q == 8'hFF;
    endsequence
    a_ind_addr: assert property (
        fld == 5'h00 |-> mode == BDM_INDIRECT && target.addr == bank_pointer_q)
        else $error("indirect address wrong");
    a_ind_bank: assert property (
        fld == 5'h00 && bank_pointer_q != 8'h00 |->
        target.is_global == (bank_pointer_q[7:4] == 4'h0))
        else $error("indirect bank wrong");
    a_dir_global: assert property (
        !fld[4] && fld != 5'h00 |-> mode == BDM_DIRECT && target.is_global
        && target.addr == {4'h0, fld[3:0]})
        else $error("direct decode wrong");
    a_semi_addr: assert property (
        fld[4] |-> mode == BDM_SEMI && !target.is_global
        && target.addr == {bank_pointer_q[7:4], fld[3:0]})
        else $error("semi-direct decode wrong");
    a_bank_keep: assert property (
        req.op == BDM_OP_BANK |=> bank_pointer_q ==
        (($past(bank_pointer_q) & 8'h8F) | ($past(wd) & 8'h70)))
        else $error("bank select wrong");
    a_ptr_write: assert property (
        req.op == BDM_OP_WRITE && fld == 5'h04 |=> bank_pointer_q == $past(wd))
        else $error("pointer write lost");
    a_ptr_wrap: assert property (
        s_ptr_full |=> bank_pointer_q == 8'h00)
        else $error("pointer wrap wrong");
    a_spec_we: assert property (
        req.op == BDM_OP_WRITE && fld == 5'h01 |-> special_we && special_addr == 4'h1)
        else $error("special write missing");
    a_ind_zero: assert property (
        fld == 5'h00 && bank_pointer_q == 8'h00 |-> !target.valid && !special_we)
        else $error("indirect zero not refused");
endmodule
bind bdm_core bdm_monitor chk (.clk(clk), .rst_n(rst_n), .req(req), .target(target),
    .mode(mode), .special_we(special_we), .special_addr(special_addr),
    .bank_pointer_q(bank_pointer_q));
`default_nettype wire

// ==== bdm_special_model.sv ====
// Model of the external special-purpose registers
`timescale 1ns/1ns
`default_nettype none
module bdm_special_model (
    input  wire logic       clk,
    input  wire logic       we,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    output var  logic [7:0] rdata
);
    logic [7:0] regs [16];
    // Byte-wide special registers written on the strobe
    always_ff @(posedge clk) begin
        if (we) begin
            regs[addr] <= wdata;
        end
    end
    assign rdata = regs[addr];
endmodule
`default_nettype wire

// ==== bdm_core_test.sv ====
// Self-checking testbench for the banked data memory
`timescale 1ns/1ns
`default_nettype none
module bdm_core_test;
    import bdm_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    bdm_req_t   req = '{BDM_OP_NONE, 5'h00, 8'h00};
    logic [7:0] sp_rd;
    logic [7:0] rdata;
    logic       sp_we;
    logic [3:0] sp_addr;
    logic [7:0] sp_wd;
    logic [7:0] ptr;
    int         bad_count = 0;
    int         compares = 0;
    always #20 clk = ~clk;
    bdm_core uut (.clk(clk), .rst_n(rst_n), .req(req), .special_rdata(sp_rd), .rdata(rdata),
        .target(), .mode(), .special_we(sp_we), .special_addr(sp_addr),
        .special_wdata(sp_wd), .bank_pointer_q(ptr));
    bdm_special_model spm (.clk(clk), .we(sp_we), .addr(sp_addr), .wdata(sp_wd),
        .rdata(sp_rd));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One request, held for one edge
    task automatic put(input bdm_op_t o, input logic [4:0] f, input logic [7:0] d);
        req = '{o, f, d};
        @(posedge clk);
        #1;
    endtask
    // Reads hold the field two edges so bank data has landed
    task automatic rd(input logic [4:0] f, input logic [7:0] exp);
        put(BDM_OP_NONE, f, 8'h00);
        put(BDM_OP_NONE, f, 8'h00);
        chk(rdata, exp);
    endtask
    task automatic t_pointer;
        put(BDM_OP_WRITE, 5'h04, 8'hFF);
        chk(ptr, 8'hFF);
        put(BDM_OP_INC, 5'h04, 8'h00);
        chk(ptr, 8'h00);
        $display("pointer test done");
    endtask
    task automatic t_bank;
        put(BDM_OP_WRITE, 5'h04, 8'h8A);
        put(BDM_OP_BANK, 5'h00, 8'h35);
        chk(ptr, 8'hBA);
        put(BDM_OP_WRITE, 5'h13, 8'hC1);
        put(BDM_OP_WRITE, 5'h04, 8'h3A);
        put(BDM_OP_WRITE, 5'h13, 8'h2D);
        rd(5'h13, 8'h2D);
        put(BDM_OP_WRITE, 5'h04, 8'hB0);
        rd(5'h13, 8'hC1);
        put(BDM_OP_INC, 5'h13, 8'h00);
        rd(5'h13, 8'hC2);
        $display("bank test done");
    endtask
    task automatic t_indirect;
        put(BDM_OP_WRITE, 5'h04, 8'hF5);
        put(BDM_OP_WRITE, 5'h00, 8'h01);
        put(BDM_OP_WRITE, 5'h04, 8'hF0);
        rd(5'h15, 8'h01);
        put(BDM_OP_WRITE, 5'h04, 8'h09);
        put(BDM_OP_WRITE, 5'h00, 8'h5A);
        put(BDM_OP_WRITE, 5'h04, 8'hF9);
        rd(5'h09, 8'h5A);
        $display("indirect test done");
    endtask
    task automatic t_globals;
        put(BDM_OP_WRITE, 5'h04, 8'h00);
        put(BDM_OP_WRITE, 5'h1F, 8'h77);
        put(BDM_OP_WRITE, 5'h04, 8'h0F);
        put(BDM_OP_WRITE, 5'h00, 8'h11);
        put(BDM_OP_WRITE, 5'h04, 8'h00);
        rd(5'h1F, 8'h77);
        rd(5'h0F, 8'h11);
        put(BDM_OP_WRITE, 5'h01, 8'h3C);
        rd(5'h01, 8'h3C);
        put(BDM_OP_INC, 5'h01, 8'h00);
        rd(5'h01, 8'h3D);
        rd(5'h00, 8'h00);
        $display("globals test done");
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(ptr, 8'h00);
        t_pointer();
        t_bank();
        t_indirect();
        t_globals();
        wrap_up();
    end
endmodule
`default_nettype wire
